// ### rtl/vrc_consts.svh
// vrc_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the timer, the register bank and the bench
`ifndef VRC_CONSTS_SVH
`define VRC_CONSTS_SVH

// register offsets within the module window
`define VRC_OFS_BASE_UPPER   16'h1012
`define VRC_OFS_BASE_LOWER   16'h1014
`define VRC_OFS_SHOT_RESET   16'h1016
`define VRC_OFS_CHAIN_CTRL   16'h101a
`define VRC_OFS_IRQ_THRESH   16'h1020
`define VRC_OFS_STATUS       16'h1022
`define VRC_OFS_TALLY_LOWER  16'h1024
`define VRC_OFS_TALLY_UPPER  16'h1026
`define VRC_OFS_NEXT_EVENT   16'h1028
`define VRC_OFS_NEXT_WORD    16'h102a
`define VRC_OFS_FC_WINDOW    16'h102e

// field positions
`define VRC_CHAIN_FIRST_BIT  0
`define VRC_CHAIN_LAST_BIT   1
`define VRC_STAT_EMPTY_BIT   0
`define VRC_STAT_FULL_BIT    2
`define VRC_STAT_CARD_LSB    4
`define VRC_THRESH_W         5
`define VRC_FC_W             10
`define VRC_TALLY_W          24
`define VRC_PTR_W            10

// reset values
`define VRC_RST_THRESH       5'h00
`define VRC_RST_FC           10'h000
`define VRC_RST_BASE         8'h00
// card type code, value is arbitrary
`define VRC_CARD_CODE        4'ha

// fast-clear window: fixed part 7 us, step 1/32 us, clock 8 ns
`define VRC_FC_FIXED_NS      7000
`define VRC_CLK_NS           8
`define VRC_FC_STEP_NS       31.25
`define VRC_FC_FIXED_CYC     ((`VRC_FC_FIXED_NS + `VRC_CLK_NS - 1) / `VRC_CLK_NS)

`endif

// ### rtl/vrc_pkg.sv
// vrc_pkg.sv: types shared by the register bank files
// assumes: constants come from vrc_consts.svh
package vrc_pkg;
	typedef enum logic [2:0] {
		VRC_FC_IDLE = 3'b001,
		VRC_FC_OPEN = 3'b010,
		VRC_FC_DONE = 3'b100
	} vrc_fc_state_t;
	typedef logic [15:0] vrc_word_t;
endpackage

// ### rtl/vrc_fc_timer.sv
// vrc_fc_timer.sv: fast-clear window timer, 7 us plus N steps of 1/32 us
// assumes: one 125 MHz clock, start is a one-cycle pulse
`timescale 1ns/1ps
`include "vrc_consts.svh"
module vrc_fc_timer
	import vrc_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// control
	input  wire logic                  start,
	input  wire logic [`VRC_FC_W-1:0]  n_steps,
	// result
	output logic                       window_open
);
	vrc_fc_state_t state_r;
	logic [15:0]   cyc_r;
	logic [15:0]   limit_nxt;

	// steps are 31.25 ns = 3.90625 cycles; use n*125/32, rounded down
	always_comb begin
		limit_nxt = 16'(`VRC_FC_FIXED_CYC) + 16'((32'(n_steps) * 32'd125) >> 5);
	end

	// window sequencer, a fresh start reopens the window
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= VRC_FC_IDLE;
			cyc_r   <= 16'h0000;
		end else begin
			case (state_r)
				VRC_FC_IDLE, VRC_FC_DONE: begin
					if (start) begin
						state_r <= VRC_FC_OPEN;
						cyc_r   <= 16'h0001;
					end else begin
						state_r <= VRC_FC_IDLE;
					end
				end
				VRC_FC_OPEN: begin
					if (start) begin
						cyc_r <= 16'h0001;
					end else if (cyc_r >= limit_nxt) begin
						state_r <= VRC_FC_DONE;
					end else begin
						cyc_r <= cyc_r + 16'h0001;
					end
				end
				default: state_r <= VRC_FC_IDLE;
			endcase
		end
	end

	assign window_open = (state_r == VRC_FC_OPEN);
endmodule // vrc_fc_timer

// ### rtl/vrc_regs.sv
// vrc_regs.sv: readout control and status register bank
// assumes: 16-bit bus strobes, one clock; buffer, trigger and mode
// signals come synchronous from the acquisition core.
//
// Function
// - base_address_upper holds A31..A24, writes relocate the module.
// - base_address_lower holds A23..A16, writes relocate the module.
// - any write to single-shot reset pulses module reset; base address is kept.
// - chain bits first/last encode disabled, first, last, intermediate.
// - 5-bit threshold raises interrupt when stored events equal it.
// - threshold resets to zero; zero disables event interrupt.
// - status empty flag reads 1 when output buffer holds nothing.
// - status full flag reads 1 when output buffer is full.
// - four status bits give fixed daughter card type code.
// - 24-bit event tally, low 16 and high 8 bits readable.
// - tally counts all triggers or accepted ones per mode bit 14.
// - tally cleared by counter-reset write, software or hardware reset.
// - in accepted-only mode a data reset also clears tally.
// - write to next-event moves pointer to next event start.
// - write to next-word advances one word, crossing end marker.
// - auto-advance off means pointer moves only on those writes.
// - 10-bit count sets fast-clear window of N steps plus 7 us.
// - auto-advance on moves pointer as words are read out.
`timescale 1ns/1ps
`include "vrc_consts.svh"
module vrc_regs
	import vrc_pkg::*;
(
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// register access
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [15:0]              reg_addr,
	input  wire logic [15:0]              reg_wdata,
	output logic [15:0]                   reg_rdata_r,
	// resets and mode from the core
	input  wire logic                     soft_rst,
	input  wire logic                     data_rst,
	input  wire logic                     tally_clr_wr,
	input  wire logic                     count_every_trigger,
	input  wire logic                     pointer_auto_advance,
	// acquisition events
	input  wire logic                     trig_any,
	input  wire logic                     trig_accepted,
	input  wire logic                     evt_stored,
	input  wire logic                     evt_read_done,
	input  wire logic                     buf_empty,
	input  wire logic                     buf_full,
	input  wire logic                     word_read,
	input  wire logic                     word_is_end,
	input  wire logic [`VRC_PTR_W-1:0]    next_event_addr,
	input  wire logic                     fc_start,
	// results
	output logic                          module_rst_r,
	output logic [7:0]                    base_address_upper_r,
	output logic [7:0]                    base_address_lower_r,
	output logic                          chain_first_r,
	output logic                          chain_last_r,
	output logic                          evt_irq_r,
	output logic [`VRC_PTR_W-1:0]         rd_ptr_r,
	output logic                          fc_window_r
);
	logic [`VRC_THRESH_W-1:0] thresh_r;
	logic [`VRC_FC_W-1:0]     fc_n_r;
	logic [`VRC_TALLY_W-1:0]  tally_r;
	logic [5:0]               stored_r;
	logic [5:0]               stored_nxt;
	logic                     fc_open;
	logic                     wr_hit_upper, wr_hit_lower, wr_hit_shot, wr_hit_chain;
	logic                     wr_hit_thresh, wr_hit_fc, wr_hit_nev, wr_hit_nword;

	////////////////////////////////////////////////////////////////////////
	// write decode
	assign wr_hit_upper  = reg_wr && (reg_addr == `VRC_OFS_BASE_UPPER);
	assign wr_hit_lower  = reg_wr && (reg_addr == `VRC_OFS_BASE_LOWER);
	assign wr_hit_shot   = reg_wr && (reg_addr == `VRC_OFS_SHOT_RESET);
	assign wr_hit_chain  = reg_wr && (reg_addr == `VRC_OFS_CHAIN_CTRL);
	assign wr_hit_thresh = reg_wr && (reg_addr == `VRC_OFS_IRQ_THRESH);
	assign wr_hit_fc     = reg_wr && (reg_addr == `VRC_OFS_FC_WINDOW);
	assign wr_hit_nev    = reg_wr && (reg_addr == `VRC_OFS_NEXT_EVENT);
	assign wr_hit_nword  = reg_wr && (reg_addr == `VRC_OFS_NEXT_WORD);

	////////////////////////////////////////////////////////////////////////
	// base address relocation; only low byte kept, upper bits ignored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			base_address_upper_r <= `VRC_RST_BASE;
			base_address_lower_r <= `VRC_RST_BASE;
		end else begin
			if (wr_hit_upper)
				base_address_upper_r <= reg_wdata[7:0];
			if (wr_hit_lower)
				base_address_lower_r <= reg_wdata[7:0];
		end
	end

	// single-shot reset: data value discarded, one-cycle pulse out
	always_ff @(posedge clk) begin
		if (sys_rst)
			module_rst_r <= 1'b0;
		else
			module_rst_r <= wr_hit_shot;
	end

	// chain role; the two bits are the whole encoding
	always_ff @(posedge clk) begin
		if (sys_rst || module_rst_r) begin
			chain_first_r <= 1'b0;
			chain_last_r  <= 1'b0;
		end else if (wr_hit_chain) begin
			chain_first_r <= reg_wdata[`VRC_CHAIN_FIRST_BIT];
			chain_last_r  <= reg_wdata[`VRC_CHAIN_LAST_BIT];
		end
	end

	// threshold and fast-clear count
	always_ff @(posedge clk) begin
		if (sys_rst || module_rst_r) begin
			thresh_r <= `VRC_RST_THRESH;
			fc_n_r   <= `VRC_RST_FC;
		end else begin
			if (wr_hit_thresh)
				thresh_r <= reg_wdata[`VRC_THRESH_W-1:0];
			if (wr_hit_fc)
				fc_n_r <= reg_wdata[`VRC_FC_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stored-event count, saturating; data reset empties the buffer
	always_comb begin
		stored_nxt = stored_r;
		if (evt_stored && !evt_read_done && stored_r != 6'h3f)
			stored_nxt = stored_r + 6'h01;
		else if (!evt_stored && evt_read_done && stored_r != 6'h00)
			stored_nxt = stored_r - 6'h01;
	end

	always_ff @(posedge clk) begin
		if (sys_rst || module_rst_r || soft_rst || data_rst)
			stored_r <= 6'h00;
		else
			stored_r <= stored_nxt;
	end

	// irq level while count equals threshold; zero disables
	// a cycle that empties the count must not flag the stale value
	always_ff @(posedge clk) begin
		if (sys_rst || module_rst_r)
			evt_irq_r <= 1'b0;
		else
			evt_irq_r <= !soft_rst && !data_rst && (thresh_r != 5'h00)
				&& (stored_nxt == {1'b0, thresh_r});
	end

	////////////////////////////////////////////////////////////////////////
	// event tally; set loses to clear since the core cleared the data
	always_ff @(posedge clk) begin
		if (sys_rst || module_rst_r || soft_rst || tally_clr_wr)
			tally_r <= 24'h000000;
		else if (data_rst && !count_every_trigger)
			tally_r <= 24'h000000;
		else if (count_every_trigger ? trig_any : trig_accepted)
			tally_r <= tally_r + 24'h000001;
	end

	////////////////////////////////////////////////////////////////////////
	// read pointer: manual writes always act, readout only in auto mode
	always_ff @(posedge clk) begin
		if (sys_rst || module_rst_r || soft_rst || data_rst)
			rd_ptr_r <= '0;
		else if (wr_hit_nev)
			rd_ptr_r <= next_event_addr;
		else if (wr_hit_nword)
			rd_ptr_r <= word_is_end ? next_event_addr : rd_ptr_r + 10'h001;
		else if (pointer_auto_advance && word_read)
			rd_ptr_r <= rd_ptr_r + 10'h001;
	end

	////////////////////////////////////////////////////////////////////////
	// fast-clear window
	vrc_fc_timer u_fc (
		.clk         (clk),
		.sys_rst     (sys_rst || module_rst_r),
		.start       (fc_start),
		.n_steps     (fc_n_r),
		.window_open (fc_open)
	);

	always_ff @(posedge clk) begin
		if (sys_rst)
			fc_window_r <= 1'b0;
		else
			fc_window_r <= fc_open;
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; unmapped and write-only locations read zero
	always_ff @(posedge clk) begin
		if (sys_rst)
			reg_rdata_r <= 16'h0000;
		else if (reg_rd) begin
			case (reg_addr)
				`VRC_OFS_BASE_UPPER:  reg_rdata_r <= {8'h00, base_address_upper_r};
				`VRC_OFS_BASE_LOWER:  reg_rdata_r <= {8'h00, base_address_lower_r};
				`VRC_OFS_CHAIN_CTRL:  reg_rdata_r <= {14'h0000, chain_last_r, chain_first_r};
				`VRC_OFS_IRQ_THRESH:  reg_rdata_r <= {11'h000, thresh_r};
				`VRC_OFS_STATUS: begin
					reg_rdata_r <= 16'h0000;
					reg_rdata_r[`VRC_STAT_EMPTY_BIT] <= buf_empty;
					reg_rdata_r[`VRC_STAT_FULL_BIT]  <= buf_full;
					reg_rdata_r[`VRC_STAT_CARD_LSB +: 4] <= `VRC_CARD_CODE;
				end
				`VRC_OFS_TALLY_LOWER: reg_rdata_r <= tally_r[15:0];
				`VRC_OFS_TALLY_UPPER: reg_rdata_r <= {8'h00, tally_r[23:16]};
				`VRC_OFS_FC_WINDOW:   reg_rdata_r <= {6'h00, fc_n_r};
				default:              reg_rdata_r <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_shot_reset;
		@(posedge clk) disable iff (sys_rst) wr_hit_shot |=> module_rst_r;
	endproperty
	a_shot_reset: assert property (p_shot_reset) else $error("shot reset missed");

	property p_irq_zero;
		@(posedge clk) disable iff (sys_rst) (thresh_r == 5'h00) |=> !evt_irq_r;
	endproperty
	a_irq_zero: assert property (p_irq_zero) else $error("irq with zero threshold");

	property p_irq_eq;
		@(posedge clk) disable iff (sys_rst || module_rst_r)
			evt_irq_r |-> ($past(stored_nxt) == {1'b0, $past(thresh_r)});
	endproperty
	a_irq_eq: assert property (p_irq_eq) else $error("irq without match");

	property p_tally_clr;
		@(posedge clk) disable iff (sys_rst) tally_clr_wr |=> (tally_r == 24'h000000);
	endproperty
	a_tally_clr: assert property (p_tally_clr) else $error("tally not cleared");

	property p_tally_data;
		@(posedge clk) disable iff (sys_rst)
			(data_rst && !count_every_trigger) |=> (tally_r == 24'h000000);
	endproperty
	a_tally_data: assert property (p_tally_data) else $error("tally kept on data reset");

	property p_tally_inc;
		@(posedge clk) disable iff (sys_rst)
			(!soft_rst && !tally_clr_wr && !data_rst && !module_rst_r && trig_any
			 && count_every_trigger) |=> (tally_r == $past(tally_r) + 24'h000001);
	endproperty
	a_tally_inc: assert property (p_tally_inc) else $error("tally missed trigger");

	property p_ptr_hold;
		@(posedge clk) disable iff (sys_rst)
			(!pointer_auto_advance && !wr_hit_nev && !wr_hit_nword && !soft_rst
			 && !data_rst && !module_rst_r) |=> $stable(rd_ptr_r);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");

	property p_next_event;
		@(posedge clk) disable iff (sys_rst)
			(wr_hit_nev && !soft_rst && !data_rst && !module_rst_r)
			|=> (rd_ptr_r == $past(next_event_addr));
	endproperty
	a_next_event: assert property (p_next_event) else $error("next event wrong");

	property p_base_wr;
		@(posedge clk) disable iff (sys_rst)
			wr_hit_upper |=> (base_address_upper_r == $past(reg_wdata[7:0]));
	endproperty
	a_base_wr: assert property (p_base_wr) else $error("base upper not written");

	property p_chain_wr;
		@(posedge clk) disable iff (sys_rst)
			(wr_hit_chain && !module_rst_r)
			|=> (chain_first_r == $past(reg_wdata[`VRC_CHAIN_FIRST_BIT])
				&& chain_last_r == $past(reg_wdata[`VRC_CHAIN_LAST_BIT]));
	endproperty
	a_chain_wr: assert property (p_chain_wr) else $error("chain role not written");

	property p_next_word;
		@(posedge clk) disable iff (sys_rst)
			(wr_hit_nword && !word_is_end && !soft_rst && !data_rst && !module_rst_r)
			|=> (rd_ptr_r == $past(rd_ptr_r) + 10'h001);
	endproperty
	a_next_word: assert property (p_next_word) else $error("next word wrong");

	property p_ptr_auto;
		@(posedge clk) disable iff (sys_rst)
			(pointer_auto_advance && word_read && !wr_hit_nev && !wr_hit_nword
			 && !soft_rst && !data_rst && !module_rst_r)
			|=> (rd_ptr_r == $past(rd_ptr_r) + 10'h001);
	endproperty
	a_ptr_auto: assert property (p_ptr_auto) else $error("pointer not advanced");

	property p_fc_open;
		@(posedge clk) disable iff (sys_rst)
			(fc_start && !module_rst_r) |-> ##2 fc_window_r;
	endproperty
	a_fc_open: assert property (p_fc_open) else $error("fast clear window not opened");

	c_shot:  cover property (@(posedge clk) wr_hit_shot);
	c_irq:   cover property (@(posedge clk) evt_irq_r);
	c_nword: cover property (@(posedge clk) wr_hit_nword ##1 wr_hit_nev);
	c_fc:    cover property (@(posedge clk) fc_open ##1 !fc_open);
endmodule // vrc_regs

// ### testbench/vrc_host_model.sv
// vrc_host_model.sv: bus master that issues register writes and reads
// assumes: strobes sampled on the rising edge of clk, one access at a time
`timescale 1ns/1ps
module vrc_host_model (
	// clock
	input  wire logic        clk,
	// read data from the register bank
	input  wire logic [15:0] reg_rdata_r,
	// register access
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [15:0]      reg_addr,
	output logic [15:0]      reg_wdata
);
	// quiet bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one-cycle write; released lines show inverted value, never stale data
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask
	// one-cycle read; registered data taken once it has landed
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 v = reg_rdata_r;
	endtask
endmodule // vrc_host_model

// ### testbench/vme_readout_control_registers_tb_top.sv
// vme_readout_control_registers_tb_top.sv: self-checking bench for vrc_regs
// assumes: vrc_host_model issues all register cycles
`timescale 1ns/1ps
`include "vrc_consts.svh"
module vme_readout_control_registers_tb_top;
	logic        clk, sys_rst, reg_wr, reg_rd, soft_rst, data_rst, tally_clr_wr;
	logic        count_every_trigger, pointer_auto_advance, trig_any, trig_accepted;
	logic        evt_stored, evt_read_done, buf_empty, buf_full, word_read, word_is_end;
	logic        fc_start, module_rst_r, chain_first_r, chain_last_r, evt_irq_r, fc_window_r;
	logic [15:0] reg_addr, reg_wdata, reg_rdata_r, d, w;
	logic [7:0]  base_address_upper_r, base_address_lower_r, bu;
	logic [9:0]  next_event_addr, rd_ptr_r, p;
	int          fail_count, comparisons, n, k;
	int          rst_seen = 0;

	vrc_host_model vrc_host_model_i (.clk, .reg_rdata_r, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata);
	vrc_regs vrc_regs_i (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata_r, .soft_rst, .data_rst, .tally_clr_wr, .count_every_trigger,
		.pointer_auto_advance, .trig_any, .trig_accepted, .evt_stored, .evt_read_done,
		.buf_empty, .buf_full, .word_read, .word_is_end, .next_event_addr, .fc_start,
		.module_rst_r, .base_address_upper_r, .base_address_lower_r, .chain_first_r,
		.chain_last_r, .evt_irq_r, .rd_ptr_r, .fc_window_r);

	// 8 ns clock
	always #4 clk = ~clk;
	// count module reset pulses, one write must give exactly one
	always @(negedge clk) if (module_rst_r === 1'b1) rst_seen++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] e, input string s);
		comparisons++;
		if (got !== e) begin
			fail_count++;
			$display("ERROR %0t %s got %h exp %h", $time, s, got, e);
		end
	endtask
	task automatic end_of_test();
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		vrc_host_model_i.wr(a, v);
	endtask
	task automatic rc(input logic [15:0] a, input logic [15:0] e, input string s);
		vrc_host_model_i.rd(a, d);
		chk(d, e, s);
	endtask
	// both tally halves, no latching between them
	task automatic tally(input int e);
		rc(16'h1024, e[15:0], "tally lo");
		rc(16'h1026, {8'h00, e[23:16]}, "tally hi");
	endtask
	task automatic pc();
		@(posedge clk);
		#1 chk({6'h00, rd_ptr_r}, {6'h00, p}, "ptr");
	endtask
	// window length in cycles: 7 us rounded up plus whole steps
	function automatic int fc_len(input logic [15:0] v);
		return (7000 + 7) / 8 + v * 125 / 32;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// watchdog, a hang counts as a mismatch
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		$display("ERROR %0t watchdog", $time);
		end_of_test();
	end
	// main sequence
	initial begin
		{clk, soft_rst, data_rst, tally_clr_wr, count_every_trigger, trig_any} = '0;
		{trig_accepted, evt_stored, evt_read_done, buf_full, word_read, word_is_end} = '0;
		{fc_start, next_event_addr, fail_count, comparisons} = '0;
		{sys_rst, buf_empty, pointer_auto_advance} = 3'b111;
		void'($urandom(9787));
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rc(16'h1020, 16'h0000, "thresh rst");
		rc(16'h1010, 16'h0000, "unmapped");
		rc(16'h1016, 16'h0000, "wo read");
		for (k = 0; k < 2; k++) begin
			w = 16'($urandom);
			wr(16'h1012 + 16'(2 * k), w);
			rc(16'h1012 + 16'(2 * k), {8'h00, w[7:0]}, "base rd");
			chk({8'h00, k ? base_address_lower_r : base_address_upper_r}, {8'h00, w[7:0]},
				"base out");
			if (k == 0) bu = w[7:0];
		end
		for (k = 0; k < 4; k++) begin
			wr(16'h101a, (16'($urandom) & 16'hfffc) | 16'(k));
			rc(16'h101a, 16'(k), "chain rd");
			chk({14'h0, chain_last_r, chain_first_r}, 16'(k), "chain out");
			@(posedge clk) {buf_full, buf_empty} <= 2'(k);
			rc(16'h1022, {8'h00, `VRC_CARD_CODE, 1'b0, k[1], 1'b0, k[0]}, "status");
		end
		// tally in both modes, random accepted triggers
		for (k = 0; k < 2; k++) begin
			@(posedge clk) count_every_trigger <= k[0];
			tally_clr_wr <= 1'b1;
			@(posedge clk) tally_clr_wr <= 1'b0;
			n = 0;
			repeat (5 + $urandom % 20) begin
				w = 16'($urandom);
				@(posedge clk) trig_any <= 1'b1;
				trig_accepted <= w[0];
				@(posedge clk) {trig_any, trig_accepted} <= 2'b00;
				n += k ? 1 : w[0];
			end
			tally(n);
			@(posedge clk) data_rst <= 1'b1;
			@(posedge clk) data_rst <= 1'b0;
			tally(k ? n : 0);
			@(posedge clk) soft_rst <= 1'b1;
			@(posedge clk) soft_rst <= 1'b0;
			tally(0);
		end
		// interrupt at threshold, upper write bits ignored
		wr(16'h1020, 16'hffe3);
		rc(16'h1020, 16'h0003, "thresh rd");
		for (k = 0; k < 4; k++) begin
			// k=2 stores and reads together, count holds: 1, 2, 2, 3
			@(posedge clk) evt_stored <= 1'b1;
			evt_read_done <= (k == 2);
			@(posedge clk) {evt_stored, evt_read_done} <= 2'b00;
			repeat (2) @(posedge clk);
			#1 chk(16'(evt_irq_r), 16'(k == 3), "irq");
		end
		wr(16'h1020, 16'h0000);
		repeat (2) @(posedge clk);
		#1 chk(16'(evt_irq_r), 16'h0000, "irq off");
		// read pointer, auto advance on then off
		p = 10'h000;
		for (k = 0; k < 2; k++) begin
			@(posedge clk) pointer_auto_advance <= !k;
			repeat (3) begin
				@(posedge clk) word_read <= 1'b1;
				@(posedge clk) word_read <= 1'b0;
			end
			p = 10'd3;
			pc();
		end
		wr(16'h102a, 16'($urandom));
		p = 10'd4;
		pc();
		@(posedge clk) next_event_addr <= 10'($urandom);
		word_is_end <= 1'b1;
		wr(16'h102a, 16'($urandom));
		p = next_event_addr;
		pc();
		@(posedge clk) next_event_addr <= 10'($urandom);
		word_is_end <= 1'b0;
		wr(16'h1028, 16'($urandom));
		p = next_event_addr;
		pc();
		// fast-clear window, counts 0x010 and 0x3f0, both below the 10-bit maximum
		for (k = 0; k < 2; k++) begin
			w = k ? 16'h03f0 : 16'h0010;
			wr(16'h102e, {6'h3f, w[9:0]});
			rc(16'h102e, w, "fc rd");
			@(posedge clk) fc_start <= 1'b1;
			@(posedge clk) fc_start <= 1'b0;
			n = 0;
			repeat (6000) begin
				@(posedge clk);
				#1 if (fc_window_r === 1'b1) n++;
			end
			chk(16'(n), 16'(fc_len(w)), "fc len");
		end
		// debug-only reset location, used once here
		wr(16'h1016, 16'($urandom));
		repeat (3) @(posedge clk);
		chk(16'(rst_seen), 16'h0001, "module rst");
		rc(16'h102e, 16'h0000, "fc cleared");
		rc(16'h101a, 16'h0000, "chain cleared");
		rc(16'h1012, {8'h00, bu}, "base kept");
		end_of_test();
	end
endmodule // vme_readout_control_registers_tb_top
